//--- include/sfs_pkg.sv
// Purpose: constants and types for the system fault supervisor
// Assumes: 125 MHz system clock
// Notes:   register offsets are byte addresses on a 32-bit bus
package sfs_pkg;
   localparam int unsigned CLK_MHZ          = 125;
   localparam int unsigned UV_FILTER_NS     = 20000;
   // at least the filter time: round up
   localparam int unsigned UV_FILTER_CYC    = (UV_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned UV_CNT_W         = 12;
   localparam logic [UV_CNT_W-1:0] UV_CNT_MAX = UV_CNT_W'(UV_FILTER_CYC);

   localparam logic [3:0] ADDR_STATUS    = 4'h0;
   localparam logic [3:0] ADDR_IRQ       = 4'h4;
   localparam logic [3:0] ADDR_MASK      = 4'h8;
   localparam logic [3:0] ADDR_CTRL      = 4'hc;

   localparam int unsigned EV_W          = 5;
   localparam int unsigned EV_WARN1      = 0;
   localparam int unsigned EV_WARN2      = 1;
   localparam int unsigned EV_UV         = 2;
   localparam int unsigned EV_IO         = 3;
   localparam int unsigned EV_THERM      = 4;
   localparam logic [EV_W-1:0] MASK_RST  = 5'h1f;
   localparam logic [3:0]  OUT_EN_RST    = 4'h0;
   // edges after reset release until both synchroniser stages hold pin levels
   localparam logic [1:0]  SYNC_FILL_CYC = 2'h2;

   typedef enum logic [2:0] {
      SFS_FOUR       = 3'b000,
      SFS_THREE_ONE  = 3'b001,
      SFS_TWO_TWO    = 3'b010,
      SFS_TWO_ONE_ONE= 3'b011,
      SFS_ALL_SINGLE = 3'b100
   } sfs_phase_e;

   typedef struct packed {
      logic supply_low;
      logic supply_above_rise;
      logic io_ok;
      logic temp_shdn;
      logic temp_recovered;
      logic warn1;
      logic warn2;
      logic general_input_one;
   } sfs_ind_s;
endpackage

//--- verilog/sfs_sync.sv
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: inputs asynchronous to clk
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module sfs_sync #(
   parameter int unsigned W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_next;

   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= meta_next;
         q        <= q_next;
      end
   end
endmodule

//--- verilog/sfs_supervisor.sv
// Purpose: system fault supervisor with Avalon-MM registers
// Assumes: comparator indications arrive as asynchronous levels
// Notes:   RST stands for power-on reset
// Operation
// R1 - latch phase select pins once at reset
// R2 - low top bit: decode lower two bits
// R3 - high top bit: four single outputs
// R4 - supply low over 20us forces shutdown
// R5 - undervoltage recovery when above rising limit
// R6 - host keeps falling limit below rising
// R7 - io supply loss shuts down until ok
// R8 - overtemp turns outputs off, resets registers
// R9 - serial access alive during thermal shutdown
// R10 - thermal recovery on recovery indication
// R11 - two warning comparators raise interrupts
// R12 - general input one active high
// R13 - every shutdown resets off-reset registers
// R14 - interrupts on condition edges only
// R15 - synchronise all comparator indications
`timescale 1ns/100ps
module sfs_supervisor
   import sfs_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        PHASE_SELECT_BIT0,
   input  wire logic        PHASE_SELECT_BIT1,
   input  wire logic        PHASE_SELECT_BIT2,
   input  wire logic        SUPPLY_LOW,
   input  wire logic        SUPPLY_ABOVE_RISE,
   input  wire logic        IO_SUPPLY_OK,
   input  wire logic        TEMP_SHDN,
   input  wire logic        TEMP_RECOVERED,
   input  wire logic        TEMP_WARN1,
   input  wire logic        TEMP_WARN2,
   input  wire logic        GENERAL_INPUT_ONE,
   input  wire logic [3:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic      [2:0]  PHASE_MODE,
   output logic      [3:0]  OUTPUT_ENABLE,
   output logic             SHUTDOWN,
   output logic             OFF_RESET,
   output logic             SERIAL_ALIVE,
   output logic             GENERAL_INPUT_ACTIVE,
   output logic             IRQ
);
   // synchronised indications
   sfs_ind_s ind_raw;
   sfs_ind_s ind;

   always_comb begin
      ind_raw.supply_low        = SUPPLY_LOW;
      ind_raw.supply_above_rise = SUPPLY_ABOVE_RISE;
      ind_raw.io_ok             = IO_SUPPLY_OK;
      ind_raw.temp_shdn         = TEMP_SHDN;
      ind_raw.temp_recovered    = TEMP_RECOVERED;
      ind_raw.warn1             = TEMP_WARN1;
      ind_raw.warn2             = TEMP_WARN2;
      ind_raw.general_input_one = GENERAL_INPUT_ONE;
   end

   // R15 two-flop synchronisers
   sfs_sync #(
      .W ($bits(sfs_ind_s))
   ) u_sync (
      .clk (CLK_SYS),
      .rst (RST),
      .d   (ind_raw),
      .q   (ind)
   );

   logic [2:0] sel_sync;
   sfs_sync #(
      .W (3)
   ) u_sel_sync (
      .clk (CLK_SYS),
      .rst (RST),
      .d   ({PHASE_SELECT_BIT2, PHASE_SELECT_BIT1, PHASE_SELECT_BIT0}),
      .q   (sel_sync)
   );

   // phase select capture after reset release
   logic [2:0] sel_reg;
   logic [2:0] sel_next;
   logic [1:0] cap_cnt_reg;
   logic [1:0] cap_cnt_next;
   logic       captured_reg;
   logic       captured_next;

   always_comb begin
      sel_next      = sel_reg;
      cap_cnt_next  = cap_cnt_reg;
      captured_next = captured_reg;
      if (!captured_reg) begin
         // wait for synchroniser to fill
         if (cap_cnt_reg == SYNC_FILL_CYC) begin
            // R1 capture once
            sel_next      = sel_sync;
            captured_next = 1'b1;
         end else begin
            cap_cnt_next = cap_cnt_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         sel_reg      <= 3'h0;
         cap_cnt_reg  <= 2'h0;
         captured_reg <= 1'b0;
      end else begin
         sel_reg      <= sel_next;
         cap_cnt_reg  <= cap_cnt_next;
         captured_reg <= captured_next;
      end
   end

   // reset zeros in the synchronisers are no pin levels; ok-type inputs idle high
   logic sync_full;
   assign sync_full = (cap_cnt_reg == SYNC_FILL_CYC);

   // phase decode
   sfs_phase_e mode_reg;
   sfs_phase_e mode_next;

   always_comb begin
      if (sel_reg[2]) begin
         // R3 lower bits ignored
         mode_next = SFS_ALL_SINGLE;
      end else begin
         // R2 two-bit decode
         case (sel_reg[1:0])
            2'b00:   mode_next = SFS_FOUR;
            2'b01:   mode_next = SFS_THREE_ONE;
            2'b10:   mode_next = SFS_TWO_TWO;
            2'b11:   mode_next = SFS_TWO_ONE_ONE;
            default: mode_next = SFS_FOUR;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         mode_reg <= SFS_FOUR;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // fault state
   logic [UV_CNT_W-1:0] uv_cnt_reg;
   logic [UV_CNT_W-1:0] uv_cnt_next;
   logic                uv_fault_reg;
   logic                uv_fault_next;
   logic                io_fault_reg;
   logic                io_fault_next;
   logic                th_fault_reg;
   logic                th_fault_next;
   logic                uv_trip;
   logic                io_trip;
   logic                th_trip;
   logic                shutdown_reg;
   logic                shutdown_next;

   always_comb begin
      uv_cnt_next   = uv_cnt_reg;
      uv_fault_next = uv_fault_reg;
      io_fault_next = io_fault_reg;
      th_fault_next = th_fault_reg;
      // R4 filter short dips
      if (!ind.supply_low) begin
         uv_cnt_next = '0;
      end else if (uv_cnt_reg != UV_CNT_MAX) begin
         uv_cnt_next = uv_cnt_reg + UV_CNT_W'(1);
      end
      uv_trip = ind.supply_low && (uv_cnt_reg == UV_CNT_MAX) && !uv_fault_reg;
      if (uv_trip) begin
         uv_fault_next = 1'b1;
      end else if (uv_fault_reg && ind.supply_above_rise && !ind.supply_low) begin
         // R5 leave dormant state
         uv_fault_next = 1'b0;
      end
      // R7 io supply fault
      io_trip = sync_full && !ind.io_ok && !io_fault_reg;
      if (sync_full && !ind.io_ok) begin
         io_fault_next = 1'b1;
      end else begin
         io_fault_next = 1'b0;
      end
      // R8 thermal trip, R10 recovery
      th_trip = ind.temp_shdn && !th_fault_reg;
      if (ind.temp_shdn) begin
         th_fault_next = 1'b1;
      end else if (th_fault_reg && ind.temp_recovered) begin
         th_fault_next = 1'b0;
      end
      shutdown_next = uv_fault_next || io_fault_next || th_fault_next;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         uv_cnt_reg   <= '0;
         uv_fault_reg <= 1'b0;
         io_fault_reg <= 1'b0;
         th_fault_reg <= 1'b0;
         shutdown_reg <= 1'b0;
      end else begin
         uv_cnt_reg   <= uv_cnt_next;
         uv_fault_reg <= uv_fault_next;
         io_fault_reg <= io_fault_next;
         th_fault_reg <= th_fault_next;
         shutdown_reg <= shutdown_next;
      end
   end

   logic shutdown;
   logic off_reset;
   // R13 any fault shuts down
   assign shutdown  = shutdown_reg;
   assign off_reset = shutdown;

   // warning edge detect
   logic            w1_d_reg;
   logic            w1_d_next;
   logic            w2_d_reg;
   logic            w2_d_next;
   logic [EV_W-1:0] ev;

   always_comb begin
      w1_d_next = ind.warn1;
      w2_d_next = ind.warn2;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         w1_d_reg <= 1'b0;
         w2_d_reg <= 1'b0;
      end else begin
         w1_d_reg <= w1_d_next;
         w2_d_reg <= w2_d_next;
      end
   end

   // R11 R14 rising edges only
   always_comb begin
      ev           = '0;
      ev[EV_WARN1] = ind.warn1 && !w1_d_reg;
      ev[EV_WARN2] = ind.warn2 && !w2_d_reg;
      ev[EV_UV]    = uv_trip;
      ev[EV_IO]    = io_trip;
      ev[EV_THERM] = th_trip;
   end

   // register file
   logic [EV_W-1:0]  irq_reg;
   logic [EV_W-1:0]  irq_next;
   logic [EV_W-1:0]  mask_reg;
   logic [EV_W-1:0]  mask_next;
   logic [3:0]       oen_reg;
   logic [3:0]       oen_next;
   logic [3:0]       oe_out_reg;
   logic [3:0]       oe_out_next;
   logic             irq_out_reg;
   logic             irq_out_next;
   logic [31:0]      rdata_reg;
   logic [31:0]      rdata_next;
   logic             ack_reg;
   logic             ack_next;
   logic             req;
   logic             rd_take;
   logic             wr_take;
   logic             bus_ok;

   // R9 bus serviced while supplies valid
   assign bus_ok  = !uv_fault_reg && !io_fault_reg;
   assign req     = AVS_READ || AVS_WRITE;
   assign rd_take = AVS_READ && ack_reg;
   assign wr_take = AVS_WRITE && ack_reg;

   always_comb begin
      ack_next   = req && !ack_reg && bus_ok;
      rdata_next = rdata_reg;
      irq_next   = irq_reg;
      mask_next  = mask_reg;
      oen_next   = oen_reg;
      if (AVS_READ && !ack_reg && bus_ok) begin
         case (AVS_ADDRESS)
            ADDR_STATUS: rdata_next = {24'h0, ind.general_input_one, sel_reg,
                                       th_fault_reg, io_fault_reg, uv_fault_reg, shutdown};
            ADDR_IRQ:    rdata_next = {27'h0, irq_reg};
            ADDR_MASK:   rdata_next = {27'h0, mask_reg};
            ADDR_CTRL:   rdata_next = {25'h0, mode_reg, oen_reg};
            default:     rdata_next = 32'h0;
         endcase
      end
      // clear only the bits the read returned, a later event survives
      if (rd_take && AVS_ADDRESS == ADDR_IRQ) begin
         irq_next = irq_reg & ~rdata_reg[EV_W-1:0];
      end
      if (wr_take && AVS_ADDRESS == ADDR_MASK) begin
         mask_next = AVS_WRITEDATA[EV_W-1:0];
      end
      if (wr_take && AVS_ADDRESS == ADDR_CTRL) begin
         oen_next = AVS_WRITEDATA[3:0];
      end
      // R8 off-reset class back to defaults
      if (off_reset) begin
         mask_next = MASK_RST;
         oen_next  = OUT_EN_RST;
      end
      // set wins over clear
      irq_next = irq_next | ev;
      // output flops loaded from next state, same timing as the state
      oe_out_next  = shutdown_next ? OUT_EN_RST : oen_next;
      irq_out_next = |(irq_next & ~mask_next);
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         irq_reg   <= '0;
         mask_reg  <= MASK_RST;
         oen_reg   <= OUT_EN_RST;
         rdata_reg <= 32'h0;
         ack_reg   <= 1'b0;
         oe_out_reg  <= OUT_EN_RST;
         irq_out_reg <= 1'b0;
      end else begin
         irq_reg   <= irq_next;
         mask_reg  <= mask_next;
         oen_reg   <= oen_next;
         rdata_reg <= rdata_next;
         ack_reg   <= ack_next;
         oe_out_reg  <= oe_out_next;
         irq_out_reg <= irq_out_next;
      end
   end

   // R12 active high input
   assign GENERAL_INPUT_ACTIVE = ind.general_input_one;
   assign AVS_READDATA         = rdata_reg;
   assign AVS_WAITREQUEST      = req && !ack_reg;
   assign PHASE_MODE           = mode_reg;
   // R8 outputs forced off
   assign OUTPUT_ENABLE        = oe_out_reg;
   assign SHUTDOWN             = shutdown;
   assign OFF_RESET            = off_reset;
   assign SERIAL_ALIVE         = bus_ok;
   assign IRQ                  = irq_out_reg;
endmodule

//--- tb/sfs_properties.sv
// Purpose: port checks of the fault supervisor
// Assumes: bound to sfs_supervisor
// Notes:   helper counters for long spans
`timescale 1ns/100ps
module sfs_properties (
   input wire logic       CLK_SYS,
   input wire logic       RST,
   input wire logic       SUPPLY_LOW,
   input wire logic       IO_SUPPLY_OK,
   input wire logic       TEMP_SHDN,
   input wire logic       GENERAL_INPUT_ONE,
   input wire logic       AVS_READ,
   input wire logic       AVS_WAITREQUEST,
   input wire logic [2:0] PHASE_MODE,
   input wire logic [3:0] OUTPUT_ENABLE,
   input wire logic       SHUTDOWN,
   input wire logic       OFF_RESET,
   input wire logic       SERIAL_ALIVE,
   input wire logic       GENERAL_INPUT_ACTIVE
);
   logic [11:0] low_cnt_reg;
   logic [11:0] low_cnt_next;
   logic [2:0]  rel_cnt_reg;
   logic [2:0]  rel_cnt_next;
   always_comb begin
      low_cnt_next = 12'h000;
      if (SUPPLY_LOW) begin
         low_cnt_next = (low_cnt_reg == 12'hfff) ? low_cnt_reg : low_cnt_reg + 12'h001;
      end
      rel_cnt_next = (rel_cnt_reg == 3'h7) ? rel_cnt_reg : rel_cnt_reg + 3'h1;
   end
   always_ff @(posedge CLK_SYS) begin
      low_cnt_reg <= RST ? 12'h000 : low_cnt_next;
      rel_cnt_reg <= RST ? 3'h0 : rel_cnt_next;
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   sequence s_one_wait;
      AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
   endsequence
   a_mode_frozen: assert property (rel_cnt_reg == 3'h7 |-> $stable(PHASE_MODE))
      else $error("phase mode changed after capture");
   a_mode_legal: assert property (PHASE_MODE[2] |-> PHASE_MODE[1:0] == 2'h0)
      else $error("illegal phase mode");
   a_outs_off: assert property (SHUTDOWN |-> OUTPUT_ENABLE == 4'h0)
      else $error("outputs on in shutdown");
   a_off_reset_tied: assert property (OFF_RESET == SHUTDOWN)
      else $error("off reset differs from shutdown");
   a_io_loss_shdn: assert property ($fell(IO_SUPPLY_OK) |-> ##[1:5] SHUTDOWN)
      else $error("no shutdown on io loss");
   a_therm_shdn: assert property ($rose(TEMP_SHDN) |-> ##[1:5] SHUTDOWN)
      else $error("no shutdown on overtemp");
   a_uv_trip: assert property (low_cnt_reg >= 12'd2510 |-> SHUTDOWN)
      else $error("no shutdown on long undervoltage");
   a_input_follow: assert property ($rose(GENERAL_INPUT_ONE) |-> ##[1:4] GENERAL_INPUT_ACTIVE)
      else $error("general input not seen");
   a_bus_wait: assert property ($rose(AVS_READ) && SERIAL_ALIVE |-> s_one_wait)
      else $error("bus answer not after one wait");
   a_enables_cleared: assert property ($fell(SHUTDOWN) |-> OUTPUT_ENABLE == 4'h0)
      else $error("enables not reset after shutdown");
endmodule
bind sfs_supervisor sfs_properties i_props (.CLK_SYS(CLK_SYS), .RST(RST), .SUPPLY_LOW(SUPPLY_LOW),
   .IO_SUPPLY_OK(IO_SUPPLY_OK), .TEMP_SHDN(TEMP_SHDN), .GENERAL_INPUT_ONE(GENERAL_INPUT_ONE),
   .AVS_READ(AVS_READ), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PHASE_MODE(PHASE_MODE),
   .OUTPUT_ENABLE(OUTPUT_ENABLE), .SHUTDOWN(SHUTDOWN), .OFF_RESET(OFF_RESET),
   .SERIAL_ALIVE(SERIAL_ALIVE), .GENERAL_INPUT_ACTIVE(GENERAL_INPUT_ACTIVE));

//--- tb/sfs_host.sv
// Purpose: host processor model on the register bus
// Assumes: one transfer at a time
// Notes:   released address and data lines show inverted values
`timescale 1ns/100ps
module sfs_host (
   input  wire logic        CLK_SYS,
   input  wire logic [31:0] AVS_READDATA,
   input  wire logic        AVS_WAITREQUEST,
   output logic      [3:0]  AVS_ADDRESS,
   output logic             AVS_READ,
   output logic             AVS_WRITE,
   output logic      [31:0] AVS_WRITEDATA
);
   initial begin
      {AVS_ADDRESS, AVS_READ, AVS_WRITE, AVS_WRITEDATA} = '0;
   end
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge CLK_SYS);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_READ <= !w;
      AVS_WRITE <= w;
      do @(posedge CLK_SYS); while (AVS_WAITREQUEST);
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
      AVS_ADDRESS <= ~a;
      AVS_WRITEDATA <= ~d;
   endtask
endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench of the fault supervisor
// Assumes: 125 MHz clock
// Notes:   expectations from a small model
`timescale 1ns/100ps
module testbench
   import sfs_pkg::*;
;
   logic CLK_SYS, RST, PHASE_SELECT_BIT0, PHASE_SELECT_BIT1, PHASE_SELECT_BIT2;
   logic SUPPLY_LOW, SUPPLY_ABOVE_RISE, IO_SUPPLY_OK, TEMP_SHDN, TEMP_RECOVERED;
   logic TEMP_WARN1, TEMP_WARN2, GENERAL_INPUT_ONE, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
   logic SHUTDOWN, OFF_RESET, SERIAL_ALIVE, GENERAL_INPUT_ACTIVE, IRQ;
   logic [3:0]  AVS_ADDRESS;
   logic [3:0]  OUTPUT_ENABLE;
   logic [2:0]  PHASE_MODE;
   logic [31:0] AVS_WRITEDATA;
   logic [31:0] AVS_READDATA;
   logic [31:0] rd;
   logic [15:0] seed = 16'h08a3;
   int          fails = 0;
   int          n_tests = 0;
   int          exp_irq = 0;
   int          exp_mode_q[$];
   sfs_supervisor i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .PHASE_SELECT_BIT0(PHASE_SELECT_BIT0),
      .PHASE_SELECT_BIT1(PHASE_SELECT_BIT1), .PHASE_SELECT_BIT2(PHASE_SELECT_BIT2),
      .SUPPLY_LOW(SUPPLY_LOW), .SUPPLY_ABOVE_RISE(SUPPLY_ABOVE_RISE), .IO_SUPPLY_OK(IO_SUPPLY_OK),
      .TEMP_SHDN(TEMP_SHDN), .TEMP_RECOVERED(TEMP_RECOVERED), .TEMP_WARN1(TEMP_WARN1),
      .TEMP_WARN2(TEMP_WARN2), .GENERAL_INPUT_ONE(GENERAL_INPUT_ONE), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PHASE_MODE(PHASE_MODE),
      .OUTPUT_ENABLE(OUTPUT_ENABLE), .SHUTDOWN(SHUTDOWN), .OFF_RESET(OFF_RESET),
      .SERIAL_ALIVE(SERIAL_ALIVE), .GENERAL_INPUT_ACTIVE(GENERAL_INPUT_ACTIVE), .IRQ(IRQ));
   sfs_host i_host (.CLK_SYS(CLK_SYS), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA));
   always #4 CLK_SYS = ~CLK_SYS;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [2:0] mode_of(input int p);
      return p[2] ? 3'h4 : {1'b0, p[1:0]};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge CLK_SYS);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("FAIL at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      tick(20000);
      fails++;
      wrap_up();
   end
   initial begin
      {CLK_SYS, RST, PHASE_SELECT_BIT2, PHASE_SELECT_BIT1, PHASE_SELECT_BIT0} = 5'h08;
      {SUPPLY_LOW, SUPPLY_ABOVE_RISE, IO_SUPPLY_OK, TEMP_SHDN} = 4'h6;
      {TEMP_RECOVERED, TEMP_WARN1, TEMP_WARN2, GENERAL_INPUT_ONE} = 4'h0;
      tick(16);
      for (int p = 0; p < 8; p++) begin
         {PHASE_SELECT_BIT2, PHASE_SELECT_BIT1, PHASE_SELECT_BIT0} <= 3'(p);
         RST <= 1'b1;
         exp_mode_q.push_back(int'(mode_of(p)));
         tick(2);
         RST <= 1'b0;
         tick(6);
         {PHASE_SELECT_BIT2, PHASE_SELECT_BIT1, PHASE_SELECT_BIT0} <= ~3'(p);
         tick(6);
         chk(32'(PHASE_MODE), 32'(exp_mode_q.pop_front()));
      end
      $display("phase test done");
      seed = lfsr(seed);
      i_host.xfer(1'b1, ADDR_CTRL, {28'h0, seed[3:0]}, rd);
      i_host.xfer(1'b0, ADDR_CTRL, 32'h0, rd);
      chk(rd & 32'h7f, {25'h0, mode_of(7), seed[3:0]});
      chk(32'(OUTPUT_ENABLE), 32'(seed[3:0]));
      i_host.xfer(1'b0, 4'h1, 32'h0, rd);
      chk(rd, 32'h0);
      i_host.xfer(1'b1, ADDR_MASK, 32'h0, rd);
      TEMP_WARN1 <= 1'b1;
      TEMP_WARN2 <= 1'b1;
      tick(6);
      chk(32'(IRQ), 32'h1);
      i_host.xfer(1'b0, ADDR_IRQ, 32'h0, rd);
      exp_irq = exp_irq | (1 << EV_WARN1) | (1 << EV_WARN2);
      chk(rd, 32'(exp_irq));
      exp_irq = 0;
      i_host.xfer(1'b0, ADDR_IRQ, 32'h0, rd);
      chk({rd[30:0], IRQ}, 32'h0);
      $display("warning test done");
      TEMP_SHDN <= 1'b1;
      tick(6);
      chk({SHUTDOWN, OFF_RESET, OUTPUT_ENABLE}, 32'h30);
      i_host.xfer(1'b0, ADDR_MASK, 32'h0, rd);
      chk(rd, 32'(MASK_RST));
      i_host.xfer(1'b0, ADDR_IRQ, 32'h0, rd);
      exp_irq = exp_irq | (1 << EV_THERM);
      chk(rd, 32'(exp_irq));
      exp_irq = 0;
      TEMP_SHDN <= 1'b0;
      TEMP_RECOVERED <= 1'b1;
      tick(6);
      chk(32'(SHUTDOWN), 32'h0);
      $display("thermal test done");
      SUPPLY_ABOVE_RISE <= 1'b0;
      SUPPLY_LOW <= 1'b1;
      tick(2000);
      SUPPLY_LOW <= 1'b0;
      tick(6);
      chk(32'(SHUTDOWN), 32'h0);
      SUPPLY_LOW <= 1'b1;
      tick(2600);
      chk({SHUTDOWN, SERIAL_ALIVE}, 32'h2);
      SUPPLY_LOW <= 1'b0;
      tick(10);
      chk(32'(SHUTDOWN), 32'h1);
      SUPPLY_ABOVE_RISE <= 1'b1;
      tick(6);
      chk(32'(SHUTDOWN), 32'h0);
      IO_SUPPLY_OK <= 1'b0;
      tick(6);
      chk({SHUTDOWN, SERIAL_ALIVE}, 32'h2);
      IO_SUPPLY_OK <= 1'b1;
      tick(6);
      chk(32'(SHUTDOWN), 32'h0);
      $display("supply test done");
      GENERAL_INPUT_ONE <= 1'b1;
      tick(6);
      i_host.xfer(1'b0, ADDR_STATUS, 32'h0, rd);
      chk({rd[7], GENERAL_INPUT_ACTIVE}, 32'h3);
      GENERAL_INPUT_ONE <= 1'b0;
      $display("input test done");
      wrap_up();
   end
endmodule
